// ### verilog/voice_pwm_params.svh
// Offsets, field positions, reset values and timing counts of the voice PWM unit.
// Assumes a 100 MHz system clock and an 8-bit register port.
`ifndef VOICE_PWM_PARAMS_SVH
`define VOICE_PWM_PARAMS_SVH

`define OFS_AUDIO_CONTROL 8'h26
`define OFS_AUDIO_SAMPLE 8'h28
`define OFS_VOICE_ROM_DATA 8'h2a
`define OFS_ROM_ADDR_HIGH 8'h2b
`define OFS_ROM_ADDR_MID 8'h2c
`define OFS_ROM_ADDR_LOW 8'h2d
`define OFS_AUDIO_STATUS 8'h2e

`define BIT_RUN 0
`define BIT_ROM_POWER 2
`define BIT_SINGLE 3
`define BIT_RATE_LO 5
`define BIT_RATE_HI 6
`define CTRL_WRITE_MASK 8'h6d
`define CTRL_RESET 8'h00

`define SYS_CLK_HZ 100000000
`define SYS_CLK_MHZ 100
`define CARRIER_30K_HZ 30000
`define CARRIER_32K_HZ 32000
`define STEPS_30K 128
`define STEPS_32K 125
`define PRELOAD_5K 3'h6
`define PRELOAD_6K 3'h5
`define PRELOAD_8K 3'h4
`define MAX_CODE_30K 7'h7f
`define MAX_CODE_32K 7'h7c

`define ROM_LATENCY_NS 4000
`define ROM_LATENCY_CYC ((`ROM_LATENCY_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// ### verilog/voice_pwm_pkg.sv
// Types shared by the voice PWM unit.
// Assumes nothing of its surroundings.
package voice_pwm_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOPPING} pwm_state_t;

  typedef logic [1:0] rate_sel_t;

endpackage

// ### verilog/voice_pwm_audio_out.sv
// Voice PWM audio output unit with its sample FIFO and voice ROM fetch path.
// Assumes one 100 MHz clock, a synchronous ROM whose data is valid on that clock,
// and a register master that issues one-cycle strobes.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

// Synchronous FIFO with valid and ready on both sides.
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count.
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  // Storage is written only on an accepted push.
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers wrap at the depth.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Fill count tracks pushes against pops.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      count <= '0;
    end
    else if (push && !pop)
    begin
      count <= count + 1'b1;
    end
    else if (pop && !push)
    begin
      count <= count - 1'b1;
    end
  end
endmodule

`include "voice_pwm_params.svh"

// Top of the audio unit.
module voice_pwm_audio_out #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_sample_ready,
  output logic o_speaker_out_a,
  output logic o_speaker_out_b,
  output logic o_rom_power_on,
  output logic [17:0] o_rom_addr,
  input wire logic [7:0] i_rom_data
);
  localparam logic [8:0] ROM_LAT = 9'(`ROM_LATENCY_CYC);

  voice_pwm_pkg::pwm_state_t state;
  logic [7:0] audio_control;
  logic [7:0] audio_sample;
  logic [7:0] active_sample;
  logic [7:0] voice_rom_data;
  logic [1:0] rom_addr_high;
  logic [7:0] rom_addr_mid;
  logic [7:0] rom_addr_low;
  logic [8:0] rom_cnt;
  logic rom_valid;
  logic [8:0] fetch_age;
  logic run_q;
  logic [4:0] div_cnt;
  logic [7:0] step_cnt;
  logic [2:0] carrier_cnt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic run_bit;
  logic rom_power_on;
  logic single_mode;
  voice_pwm_pkg::rate_sel_t rate;
  logic tick;
  logic carrier_end;
  logic run_rise;
  logic load_now;
  logic [6:0] pwm_mag;
  logic pwm_high;
  logic addr_wr;
  logic next_out_a;
  logic next_out_b;

  // Clock cycles per step minus one; code 11 behaves as code 00.
  function automatic logic [4:0] div_of(input voice_pwm_pkg::rate_sel_t r);
    if (r == 2'b10)
      div_of = 5'(`SYS_CLK_HZ / (`CARRIER_32K_HZ * `STEPS_32K) - 1);
    else
      div_of = 5'(`SYS_CLK_HZ / (`CARRIER_30K_HZ * `STEPS_30K) - 1);
  endfunction

  // Steps in one carrier period.
  function automatic logic [7:0] steps_of(input voice_pwm_pkg::rate_sel_t r);
    steps_of = (r == 2'b10) ? 8'(`STEPS_32K) : 8'(`STEPS_30K);
  endfunction

  // Carrier periods per sample period.
  function automatic logic [2:0] preload_of(input voice_pwm_pkg::rate_sel_t r);
    if (r == 2'b01)
      preload_of = `PRELOAD_6K;
    else if (r == 2'b10)
      preload_of = `PRELOAD_8K;
    else
      preload_of = `PRELOAD_5K;
  endfunction

  // Largest code the carrier can carry.
  function automatic logic [6:0] max_of(input voice_pwm_pkg::rate_sel_t r);
    max_of = (r == 2'b10) ? `MAX_CODE_32K : `MAX_CODE_30K;
  endfunction

  // Control fields.
  assign run_bit = audio_control[`BIT_RUN];
  assign rom_power_on = audio_control[`BIT_ROM_POWER];
  assign single_mode = audio_control[`BIT_SINGLE];
  assign rate = {audio_control[`BIT_RATE_HI], audio_control[`BIT_RATE_LO]};
  assign run_rise = run_bit && !run_q;
  assign addr_wr = i_wr && ((i_addr == `OFS_ROM_ADDR_HIGH) || (i_addr == `OFS_ROM_ADDR_MID)
                   || (i_addr == `OFS_ROM_ADDR_LOW));

  // Control register; only the defined bits are stored.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      audio_control <= `CTRL_RESET;
    end
    else if (i_wr && (i_addr == `OFS_AUDIO_CONTROL))
    begin
      audio_control <= i_wdata & `CTRL_WRITE_MASK;
    end
  end

  // Last written sample, kept for readback.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      audio_sample <= 8'h00;
    end
    else if (i_wr && (i_addr == `OFS_AUDIO_SAMPLE))
    begin
      audio_sample <= i_wdata;
    end
  end

  // Samples queue here; a write while full is dropped.
  sample_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_wr && (i_addr == `OFS_AUDIO_SAMPLE)),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_wdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(load_now),
    .o_out_data(fifo_out_data)
  );

  // Step and carrier timing.
  assign tick = (div_cnt >= div_of(rate));
  assign carrier_end = tick && (step_cnt >= steps_of(rate) - 8'h01);
  assign load_now = ((state == voice_pwm_pkg::ST_IDLE) && run_rise)
                    || ((state == voice_pwm_pkg::ST_RUN) && carrier_end
                    && (carrier_cnt >= preload_of(rate) - 3'h1));

  // Run edge detector.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      run_q <= 1'b0;
    end
    else
    begin
      run_q <= run_bit;
    end
  end

  // Run, stop and drain sequencing.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state <= voice_pwm_pkg::ST_IDLE;
    end
    else
    begin
      case (state)
        voice_pwm_pkg::ST_IDLE:
        begin
          if (run_rise)
          begin
            state <= voice_pwm_pkg::ST_RUN;
          end
        end
        voice_pwm_pkg::ST_RUN:
        begin
          if (!run_bit)
          begin
            state <= carrier_end ? voice_pwm_pkg::ST_IDLE : voice_pwm_pkg::ST_STOPPING;
          end
        end
        voice_pwm_pkg::ST_STOPPING:
        begin
          if (carrier_end)
          begin
            state <= voice_pwm_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= voice_pwm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Counters restart on every start and advance while active.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || (state == voice_pwm_pkg::ST_IDLE))
    begin
      div_cnt <= 5'h00;
      step_cnt <= 8'h00;
      carrier_cnt <= 3'h0;
    end
    else
    begin
      div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
      if (carrier_end)
      begin
        step_cnt <= 8'h00;
        carrier_cnt <= (carrier_cnt >= preload_of(rate) - 3'h1) ? 3'h0 : carrier_cnt + 3'h1;
      end
      else if (tick)
      begin
        step_cnt <= step_cnt + 8'h01;
      end
    end
  end

  // Sample latch; an empty queue repeats the previous sample.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      active_sample <= 8'h00;
    end
    else if (load_now && fifo_out_valid)
    begin
      active_sample <= fifo_out_data;
    end
  end

  // Magnitude by mode, clamped to the rate's range.
  always_comb
  begin
    pwm_mag = single_mode ? active_sample[7:1] : active_sample[6:0];
    if (pwm_mag > max_of(rate))
    begin
      pwm_mag = max_of(rate);
    end
    pwm_high = ({1'b0, pwm_mag} > step_cnt);
  end

  // Output routing by mode and sign.
  always_comb
  begin
    next_out_a = 1'b0;
    next_out_b = 1'b0;
    if (state != voice_pwm_pkg::ST_IDLE)
    begin
      if (single_mode || !active_sample[7])
      begin
        next_out_a = pwm_high;
      end
      else
      begin
        next_out_b = pwm_high;
      end
    end
  end

  // Output flops.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_speaker_out_a <= 1'b0;
      o_speaker_out_b <= 1'b0;
      o_sample_ready <= 1'b0;
      o_rom_power_on <= 1'b0;
      o_rom_addr <= 18'h00000;
    end
    else
    begin
      o_speaker_out_a <= next_out_a;
      o_speaker_out_b <= next_out_b;
      o_sample_ready <= fifo_in_ready;
      o_rom_power_on <= rom_power_on;
      o_rom_addr <= {rom_addr_high, rom_addr_mid, rom_addr_low};
    end
  end

  // ROM address latches.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      rom_addr_high <= 2'h0;
      rom_addr_mid <= 8'h00;
      rom_addr_low <= 8'h00;
    end
    else if (i_wr && (i_addr == `OFS_ROM_ADDR_HIGH))
    begin
      rom_addr_high <= i_wdata[1:0];
    end
    else if (i_wr && (i_addr == `OFS_ROM_ADDR_MID))
    begin
      rom_addr_mid <= i_wdata;
    end
    else if (i_wr && (i_addr == `OFS_ROM_ADDR_LOW))
    begin
      rom_addr_low <= i_wdata;
    end
  end

  // Fetch delay; it only runs while the ROM is powered.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      rom_cnt <= 9'h000;
      rom_valid <= 1'b0;
      voice_rom_data <= 8'h00;
    end
    else if (addr_wr)
    begin
      rom_cnt <= ROM_LAT;
      rom_valid <= 1'b0;
    end
    else if (rom_power_on && (rom_cnt != 9'h000))
    begin
      rom_cnt <= rom_cnt - 9'h001;
      if (rom_cnt == 9'h001)
      begin
        voice_rom_data <= i_rom_data;
        rom_valid <= 1'b1;
      end
    end
  end

  // Cycles since the last address write, saturating; only the latency check reads it.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || addr_wr)
    begin
      fetch_age <= 9'h000;
    end
    else if (fetch_age != 9'h1ff)
    begin
      fetch_age <= fetch_age + 9'h001;
    end
  end

  // Read data, valid in the cycle after the strobe.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (!i_rd)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_addr == `OFS_AUDIO_CONTROL)
    begin
      o_rdata <= audio_control;
    end
    else if (i_addr == `OFS_AUDIO_SAMPLE)
    begin
      o_rdata <= audio_sample;
    end
    else if (i_addr == `OFS_VOICE_ROM_DATA)
    begin
      o_rdata <= voice_rom_data;
    end
    else if (i_addr == `OFS_ROM_ADDR_HIGH)
    begin
      o_rdata <= {6'h00, rom_addr_high};
    end
    else if (i_addr == `OFS_ROM_ADDR_MID)
    begin
      o_rdata <= rom_addr_mid;
    end
    else if (i_addr == `OFS_ROM_ADDR_LOW)
    begin
      o_rdata <= rom_addr_low;
    end
    else if (i_addr == `OFS_AUDIO_STATUS)
    begin
      o_rdata <= {4'h0, rom_valid, state != voice_pwm_pkg::ST_IDLE, !fifo_out_valid,
                  !fifo_in_ready};
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

  // Checks placed beside the logic above.
  sequence run_rise_s;
    (state == voice_pwm_pkg::ST_IDLE) && run_rise;
  endsequence

  sequence addr_set_s;
    addr_wr;
  endsequence

  start_run_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run_rise_s |=> (state == voice_pwm_pkg::ST_RUN))
    else $error("start did not enter run");
  stop_finish_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (state == voice_pwm_pkg::ST_STOPPING) && carrier_end |=> ##1
    (state == voice_pwm_pkg::ST_IDLE) && !o_speaker_out_a && !o_speaker_out_b)
    else $error("stop did not halt low");
  rest_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(state) == voice_pwm_pkg::ST_IDLE |-> !o_speaker_out_a && !o_speaker_out_b)
    else $error("output not low while idle");
  single_b_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(single_mode) |-> !o_speaker_out_b)
    else $error("second output active in single mode");
  sign_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !single_mode && !active_sample[7] |=> !o_speaker_out_b)
    else $error("sign 0 drove second output");
  rom_power_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_wr && (i_addr == `OFS_AUDIO_CONTROL) |=> ##1 o_rom_power_on == $past(i_wdata[2], 2))
    else $error("rom power does not follow control");
  rom_latency_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(rom_valid) |-> fetch_age >= ROM_LAT)
    else $error("rom data ready too early");
  rom_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    addr_set_s |=> rom_cnt == ROM_LAT)
    else $error("rom delay not loaded");
  unused_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rd && (i_addr == `OFS_AUDIO_CONTROL) |=> !o_rdata[7] && !o_rdata[4] && !o_rdata[1])
    else $error("unused control bits not zero");
  code_clamp_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pwm_mag <= max_of(rate))
    else $error("code above range");
  step_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (state != voice_pwm_pkg::ST_IDLE) && $stable(rate) && tick |-> step_cnt < steps_of(rate))
    else $error("step beyond carrier period");
  hold_sample_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    load_now && !fifo_out_valid |=> $stable(active_sample))
    else $error("sample changed without new data");
  reset_ctrl_a: assert property (@(posedge i_sys_clk)
    !i_rst_n |=> audio_control == 8'h00)
    else $error("reset did not clear control");
endmodule

// ### tb/speaker_model.sv
// Behavioural load on the two speaker outputs: counts the high cycles of each output.
// Assumes the outputs are sampled on the rising edge of the same system clock.
`timescale 1ns/1ps

module speaker_model (
  input wire logic i_sys_clk,
  input wire logic i_clear,
  input wire logic i_out_a,
  input wire logic i_out_b,
  output int o_high_a,
  output int o_high_b,
  output logic o_overlap
);
  // High time per output; a clear pulse opens a new measuring window.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_clear)
    begin
      o_high_a <= 0;
      o_high_b <= 0;
    end
    else
    begin
      o_high_a <= o_high_a + int'(i_out_a === 1'b1);
      o_high_b <= o_high_b + int'(i_out_b === 1'b1);
    end
  end

  // A bridge load must never see both sides driven high together.
  initial o_overlap = 1'b0;
  always @(posedge i_sys_clk)
  begin
    if (i_out_a === 1'b1 && i_out_b === 1'b1)
      o_overlap <= 1'b1;
  end
endmodule

// ### tb/voice_pwm_audio_out_tb.sv
// Self-checking bench of the voice PWM unit with a speaker load model.
// Assumes a 100 MHz clock and a one-cycle register strobe port.
`timescale 1ns/1ps
`include "voice_pwm_params.svh"

`define CHECK(name, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end

module voice_pwm_audio_out_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_rom_data = 8'h00;
  logic [7:0] o_rdata;
  logic o_sample_ready, o_speaker_out_a, o_speaker_out_b, o_rom_power_on;
  logic [17:0] o_rom_addr;
  logic clear = 1'b0;
  logic overlap;
  int high_a, high_b;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] rd_val;

  // Clock generation.
  always #5 i_sys_clk = ~i_sys_clk;

  voice_pwm_audio_out #(.FIFO_DEPTH(8)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_sample_ready(o_sample_ready), .o_speaker_out_a(o_speaker_out_a),
    .o_speaker_out_b(o_speaker_out_b), .o_rom_power_on(o_rom_power_on),
    .o_rom_addr(o_rom_addr), .i_rom_data(i_rom_data));

  speaker_model u_load (.i_sys_clk(i_sys_clk), .i_clear(clear), .i_out_a(o_speaker_out_a),
    .i_out_b(o_speaker_out_b), .o_high_a(high_a), .o_high_b(high_b), .o_overlap(overlap));

  // Voice ROM contents as a fixed function of the address.
  function automatic logic [7:0] rom_byte(input logic [17:0] a);
    return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]} ^ 8'h5a;
  endfunction

  // The ROM answers the address the unit presents.
  always @(posedge i_sys_clk) i_rom_data <= rom_byte(o_rom_addr);

  // Clocks per carrier step for a rate code.
  function automatic int step_clk(input int rate);
    if (rate == 2)
      return `SYS_CLK_HZ / (`CARRIER_32K_HZ * `STEPS_32K);
    return `SYS_CLK_HZ / (`CARRIER_30K_HZ * `STEPS_30K);
  endfunction

  // Clocks per carrier period for a rate code.
  function automatic int period_clk(input int rate);
    return step_clk(rate) * ((rate == 2) ? `STEPS_32K : `STEPS_30K);
  endfunction

  // Expected high clocks per carrier on one output.
  function automatic int exp_high(input logic [7:0] s, input bit single, input int rate,
                                  input bit side_b);
    int mag;
    int lim;
    mag = single ? int'(s[7:1]) : int'(s[6:0]);
    lim = (rate == 2) ? 124 : 127;
    if (mag > lim)
      mag = lim;
    if (single)
      return side_b ? 0 : mag * step_clk(rate);
    return (s[7] == side_b) ? mag * step_clk(rate) : 0;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask

  // Opens a window of len clocks on the load and waits for it to close.
  task automatic measure(input int len);
    @(posedge i_sys_clk);
    clear <= 1'b1;
    @(posedge i_sys_clk);
    clear <= 1'b0;
    repeat (len) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
  endtask

  // Starts the unit, checks one carrier, stops it and checks the rest level.
  task automatic pwm_case(input int rate, input bit single, input logic [7:0] s);
    logic [7:0] ctrl;
    ctrl = {1'b0, 2'(rate), 1'b0, single, 3'b000};
    wr_reg(`OFS_AUDIO_SAMPLE, s);
    wr_reg(`OFS_AUDIO_CONTROL, ctrl | 8'h01);
    repeat (10) @(posedge i_sys_clk);
    measure(period_clk(rate));
    `CHECK("high_a", exp_high(s, single, rate, 1'b0), high_a)
    `CHECK("high_b", exp_high(s, single, rate, 1'b1), high_b)
    wr_reg(`OFS_AUDIO_CONTROL, ctrl);
    repeat (period_clk(rate) + 10) @(posedge i_sys_clk);
    measure(200);
    `CHECK("stop_a", 0, high_a + high_b)
    rd_reg(`OFS_AUDIO_STATUS);
    `CHECK("active", 1'b0, rd_val[2])
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge i_sys_clk);
    fail_count++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    logic [17:0] ra;
    int p;
    ra = 18'($urandom(37));
    do_reset();
    #1;
    `CHECK("out_a_rst", 1'b0, o_speaker_out_a)
    `CHECK("out_b_rst", 1'b0, o_speaker_out_b)
    rd_reg(`OFS_AUDIO_CONTROL);
    `CHECK("ctrl_rst", 8'h00, rd_val)
    rd_reg(8'h3f);
    `CHECK("unmapped", 8'h00, rd_val)
    wr_reg(`OFS_AUDIO_CONTROL, 8'h92);
    rd_reg(`OFS_AUDIO_CONTROL);
    `CHECK("ctrl_unused", 8'h00, rd_val)
    wr_reg(`OFS_AUDIO_CONTROL, 8'h04);
    rd_reg(`OFS_AUDIO_CONTROL);
    `CHECK("ctrl_pwr", 8'h04, rd_val)
    `CHECK("rom_pwr_on", 1'b1, o_rom_power_on)
    // Voice ROM fetch through the three address latches.
    ra = 18'($urandom);
    wr_reg(`OFS_ROM_ADDR_LOW, ra[7:0]);
    wr_reg(`OFS_ROM_ADDR_MID, ra[15:8]);
    wr_reg(`OFS_ROM_ADDR_HIGH, {6'h00, ra[17:16]});
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHECK("rom_addr", ra, o_rom_addr)
    repeat (370) @(posedge i_sys_clk);
    rd_reg(`OFS_VOICE_ROM_DATA);
    `CHECK("rom_early", 8'h00, rd_val)
    repeat (30) @(posedge i_sys_clk);
    rd_reg(`OFS_VOICE_ROM_DATA);
    `CHECK("rom_data", rom_byte(ra), rd_val)
    rd_reg(`OFS_AUDIO_STATUS);
    `CHECK("rom_valid", 1'b1, rd_val[3])
    wr_reg(`OFS_AUDIO_CONTROL, 8'h00);
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHECK("rom_pwr_off", 1'b0, o_rom_power_on)
    // Rate, mode and sign combinations, with a clamp corner.
    pwm_case(0, 1'b0, {1'b0, 7'($urandom)});
    pwm_case(1, 1'b1, 8'($urandom));
    pwm_case(2, 1'b0, {1'b1, 7'($urandom)});
    pwm_case(2, 1'b1, 8'hff);
    // Two queued samples: the second is taken a sample period later, then repeated.
    wr_reg(`OFS_AUDIO_SAMPLE, 8'h23);
    wr_reg(`OFS_AUDIO_SAMPLE, 8'hb1);
    wr_reg(`OFS_AUDIO_CONTROL, 8'h41);
    p = period_clk(2);
    repeat (10) @(posedge i_sys_clk);
    measure(p);
    `CHECK("first", exp_high(8'h23, 1'b0, 2, 1'b0), high_a)
    repeat (3 * p + 100) @(posedge i_sys_clk);
    measure(p);
    `CHECK("second", exp_high(8'hb1, 1'b0, 2, 1'b1), high_b)
    repeat (3 * p - 10) @(posedge i_sys_clk);
    measure(p);
    `CHECK("repeat", exp_high(8'hb1, 1'b0, 2, 1'b1), high_b)
    `CHECK("overlap", 1'b0, overlap)
    // Fill the sample buffer until it refuses, then reset in mid-run.
    wr_reg(`OFS_AUDIO_CONTROL, 8'h44);
    repeat (p + 10) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++)
      wr_reg(`OFS_AUDIO_SAMPLE, 8'($urandom));
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHECK("ready_full", 1'b0, o_sample_ready)
    rd_reg(`OFS_AUDIO_STATUS);
    `CHECK("status_full", 2'b01, rd_val[1:0])
    wr_reg(`OFS_AUDIO_CONTROL, 8'h65);
    repeat (50) @(posedge i_sys_clk);
    do_reset();
    @(posedge i_sys_clk);
    #1;
    `CHECK("ready_rst", 1'b1, o_sample_ready)
    `CHECK("pwr_rst", 1'b0, o_rom_power_on)
    `CHECK("outs_rst", 2'b00, {o_speaker_out_a, o_speaker_out_b})
    rd_reg(`OFS_AUDIO_CONTROL);
    `CHECK("ctrl_rst2", 8'h00, rd_val)
    rd_reg(`OFS_AUDIO_STATUS);
    `CHECK("status_empty", 2'b10, rd_val[1:0])
    complete_run();
  end
endmodule
